//--- verilog/mapping_row_action_select.sv
module mapping_row_action_select
  import row_action_pkg::*;
#(
  parameter int PUSH_CYCLES = UNCOUPLE_PUSH_CYCLES,
  parameter int PULL_CYCLES = UNCOUPLE_PULL_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  cv_wr,
  input  wire logic                  cv_rd,
  input  wire logic [9:0]            cv_addr,
  input  wire logic [7:0]            cv_wdata,
  output logic      [7:0]            cv_rdata,
  output logic                       cv_rvalid,
  input  wire logic                  row_match,
  input  wire logic [7:0]            other_logic_a,
  input  wire logic [7:0]            other_logic_b,
  input  wire logic [7:0]            other_logic_c,
  input  wire logic [SLOT_COUNT-1:0] other_sound,
  output logic                       speed_hold,
  output logic                       shunting_mode,
  output logic                       optional_load,
  output logic                       primary_load,
  output logic      [2:0]            brake_select,
  output logic                       uncouple_push,
  output logic                       uncouple_pull,
  output logic                       fire_box,
  output logic                       dimmer,
  output logic                       grade_crossing,
  output logic                       bypass_delay,
  output logic                       smoke_on,
  output logic                       sound_fade,
  output logic                       brake_sound_mute,
  output logic      [2:0]            volume_step,
  output logic      [5:0]            gear_state,
  output logic      [SLOT_COUNT-1:0] slot_play
);

  logic [7:0]        words [ROW_WORDS];
  logic [7:0]        page;
  logic              uncouple_prev;
  logic              volume_prev;
  logic [31:0]       phase_count;
  uncouple_state_t   state;
  uncouple_state_t   next_state;

  function automatic logic map_hit(input logic [9:0] addr, input logic [7:0] pg);
    return (pg == ROW_PAGE) && (addr >= CV_LOGIC_A) && (addr <= CV_SOUND_D);
  endfunction

  function automatic logic [2:0] word_sel(input logic [9:0] addr);
    logic [9:0] diff;
    diff = addr - CV_LOGIC_A;
    return diff[2:0];
  endfunction

  // The same indices repeat on other pages, so the page must match too.
  wire logic       wr_hit  = cv_wr && map_hit(cv_addr, page); // [RULE19] [RULE1] [RULE14]
  wire logic       rd_hit  = map_hit(cv_addr, page);
  wire logic [2:0] wr_sel  = word_sel(cv_addr);
  wire logic [2:0] rd_sel  = word_sel(cv_addr);
  wire logic       page_wr = cv_wr && (cv_addr == CV_PAGE_INDEX);
  wire logic       page_rd = (cv_addr == CV_PAGE_INDEX);
  wire logic [7:0] next_rdata = page_rd ? page : (rd_hit ? words[rd_sel] : 8'h00);

  // A row adds its request only while its conditions hold; other rows merge in.
  wire logic [7:0] act_a = (row_match ? words[W_LOGIC_A] : 8'h00) | other_logic_a; // [RULE21]
  wire logic [7:0] act_b = (row_match ? words[W_LOGIC_B] : 8'h00) | other_logic_b; // [RULE21]
  wire logic [7:0] act_c = (row_match ? words[W_LOGIC_C] : 8'h00) | other_logic_c; // [RULE21]
  wire logic [SLOT_COUNT-1:0] row_sound = {words[W_SOUND_D], words[W_SOUND_C],
                                           words[W_SOUND_B], words[W_SOUND_A]}; // [RULE14]
  wire logic [SLOT_COUNT-1:0] act_sound =
    (row_match ? row_sound : {SLOT_COUNT{1'b0}}) | other_sound; // [RULE15] [RULE20] [RULE21]
  wire logic [SLOT_COUNT-1:0] slot_grant;

  wire logic uncouple_start = act_a[LA_UNCOUPLE] && !uncouple_prev;
  wire logic volume_release = volume_prev && !act_b[LB_VOLUME];
  wire logic push_done      = (phase_count == 32'(PUSH_CYCLES - 1));
  wire logic pull_done      = (phase_count == 32'(PULL_CYCLES - 1));
  wire logic [2:0] next_volume = (volume_step == VOL_LAST_STEP) ? VOL_FULL
                                                                : volume_step + 3'h1;

  sound_slot_limiter u_limiter (
    .request (act_sound),
    .grant   (slot_grant)
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        words[i] <= WORD_RESET;
      end
      page <= PAGE_RESET;
    end else begin
      if (page_wr) begin
        page <= cv_wdata; // [RULE19]
      end
      if (wr_hit) begin
        words[wr_sel] <= cv_wdata; // [RULE1] [RULE14]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cv_rdata  <= 8'h00;
      cv_rvalid <= 1'b0;
    end else begin
      cv_rdata  <= next_rdata;
      cv_rvalid <= cv_rd;
    end
  end

  // All six gear bits are forwarded, the two reserved ones included.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      speed_hold       <= 1'b0;
      shunting_mode    <= 1'b0;
      optional_load    <= 1'b0;
      primary_load     <= 1'b0;
      brake_select     <= 3'h0;
      fire_box         <= 1'b0;
      dimmer           <= 1'b0;
      grade_crossing   <= 1'b0;
      bypass_delay     <= 1'b0;
      smoke_on         <= 1'b0;
      sound_fade       <= 1'b0;
      brake_sound_mute <= 1'b0;
      gear_state       <= 6'h00;
      slot_play        <= {SLOT_COUNT{1'b0}};
    end else begin
      speed_hold       <= act_a[LA_HOLD]; // [RULE2]
      shunting_mode    <= act_a[LA_SHUNT]; // [RULE3]
      optional_load    <= act_a[LA_OPT_LOAD]; // [RULE4]
      primary_load     <= act_a[LA_PRIMARY_LOAD]; // [RULE4]
      brake_select     <= act_a[LA_BRAKE_HI:LA_BRAKE_LO]; // [RULE4]
      fire_box         <= act_b[LB_FIRE_BOX]; // [RULE6]
      dimmer           <= act_b[LB_DIMMER]; // [RULE7]
      grade_crossing   <= act_b[LB_CROSSING]; // [RULE8]
      bypass_delay     <= act_b[LB_NO_DELAY]; // [RULE9]
      smoke_on         <= act_b[LB_SMOKE]; // [RULE10]
      sound_fade       <= act_b[LB_FADE]; // [RULE11]
      brake_sound_mute <= act_b[LB_MUTE_BRAKE]; // [RULE11]
      gear_state       <= act_c[LC_GEAR_HI:LC_GEAR_LO]; // [RULE13]
      slot_play        <= slot_grant; // [RULE17]
    end
  end

  // The step advances on release, so holding the key does not race down.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      volume_prev <= 1'b0;
      volume_step <= VOL_FULL;
    end else begin
      volume_prev <= act_b[LB_VOLUME];
      if (volume_release) begin
        volume_step <= next_volume; // [RULE12]
      end
    end
  end

  // Once started the sequence runs to its end even if the bit drops.
  always_comb begin
    next_state = state;
    case (state)
      U_IDLE: begin
        if (uncouple_start) begin
          next_state = U_PUSH; // [RULE5]
        end
      end
      U_PUSH: begin
        if (push_done) begin
          next_state = U_PULL; // [RULE5]
        end
      end
      U_PULL: begin
        if (pull_done) begin
          next_state = U_IDLE;
        end
      end
      default: begin
        next_state = U_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state         <= U_IDLE;
      phase_count   <= 32'h0000_0000;
      uncouple_prev <= 1'b0;
      uncouple_push <= 1'b0;
      uncouple_pull <= 1'b0;
    end else begin
      state         <= next_state;
      phase_count   <= (next_state != state) ? 32'h0000_0000 : phase_count + 32'h0000_0001;
      uncouple_prev <= act_a[LA_UNCOUPLE];
      uncouple_push <= (next_state == U_PUSH); // [RULE5]
      uncouple_pull <= (next_state == U_PULL); // [RULE5]
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_word_store;
    (cv_wr && (cv_addr == CV_LOGIC_A) && (page == ROW_PAGE))
      |=> (words[W_LOGIC_A] == $past(cv_wdata));
  endproperty
  a_word_store: assert property (p_word_store) else $error("logic word not stored"); // [RULE1]

  property p_wrong_page;
    (cv_wr && (cv_addr == CV_SOUND_A) && (page != ROW_PAGE)) |=> $stable(words[W_SOUND_A]);
  endproperty
  a_wrong_page: assert property (p_wrong_page) else $error("write on foreign page"); // [RULE19]

  property p_speed_hold;
    (row_match && words[W_LOGIC_A][LA_HOLD]) |=> speed_hold;
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed hold missing"); // [RULE2]

  property p_brake_sel;
    (row_match && (other_logic_a == 8'h00))
      |=> (brake_select == $past(words[W_LOGIC_A][LA_BRAKE_HI:LA_BRAKE_LO]));
  endproperty
  a_brake_sel: assert property (p_brake_sel) else $error("brake select wrong"); // [RULE4]

  sequence s_start;
    (state == U_IDLE) && uncouple_start;
  endsequence
  sequence s_pushing;
    uncouple_push && !uncouple_pull;
  endsequence
  property p_uncouple_start;
    s_start |=> s_pushing;
  endproperty
  a_uncouple_start: assert property (p_uncouple_start) else $error("push not started"); // [RULE5]

  property p_pull_follows;
    $rose(uncouple_pull) |-> $past(uncouple_push);
  endproperty
  a_pull_follows: assert property (p_pull_follows) else $error("pull without push"); // [RULE5]

  property p_volume_step;
    (volume_release && (volume_step != VOL_LAST_STEP))
      |=> (volume_step == $past(volume_step) + 3'h1);
  endproperty
  a_volume_step: assert property (p_volume_step) else $error("volume did not step"); // [RULE12]

  property p_volume_restore;
    (volume_release && (volume_step == VOL_LAST_STEP)) |=> (volume_step == VOL_FULL);
  endproperty
  a_volume_restore: assert property (p_volume_restore) else $error("no restore"); // [RULE12]

  property p_slot_limit;
    $countones(slot_play) <= MAX_PLAYING;
  endproperty
  a_slot_limit: assert property (p_slot_limit) else $error("too many slots"); // [RULE17]

  property p_prime_mover;
    act_sound[0] |=> slot_play[0];
  endproperty
  a_prime_mover: assert property (p_prime_mover) else $error("slot one dropped"); // [RULE16]

  property p_multi_slot;
    (act_sound[1:0] == 2'b11) |=> (slot_play[1:0] == 2'b11);
  endproperty
  a_multi_slot: assert property (p_multi_slot) else $error("slots not joint"); // [RULE15]

  property p_no_match;
    (!row_match && (other_logic_a == 8'h00) && (other_logic_c == 8'h00) && (other_sound == '0))
      |=> (!speed_hold && (gear_state == 6'h00) && (slot_play == '0));
  endproperty
  a_no_match: assert property (p_no_match) else $error("action without match"); // [RULE20]

  property p_or_merge;
    other_logic_b[LB_SMOKE] |=> smoke_on;
  endproperty
  a_or_merge: assert property (p_or_merge) else $error("other row request lost"); // [RULE21]

endmodule

//--- common/row_action_pkg.sv
// Notes on behaviour
// RULE1: Three logic words per row, indices 260-262.
// RULE2: Speed-hold bit freezes speed; throttle changes sound.
// RULE3: Shunting bit selects the shunting speed.
// RULE4: Load bits and brake functions one-three.
// RULE5: Uncoupling bit runs push-then-pull sequence.
// RULE6: Fire-box bit flickers fire-box outputs.
// RULE7: Dimmer bit dims dimming outputs about 60%.
// RULE8: Grade-crossing bit enables crossing effect outputs.
// RULE9: Bit eight bypasses acceleration and braking delays.
// RULE10: Bit sixteen switches synchronized smoke generators on.
// RULE11: Sound fade and brake sound mute bits.
// RULE12: Volume key steps down, further press restores.
// RULE13: Six gear state bits; top two reserved. The code forwards all six, the top two included.
// RULE14: Four sound words, 32 slots, LSB first.
// RULE15: One row may trigger several slots together.
// RULE16: Slot one is the prime mover sound.
// RULE17: At most ten slots play at once.
// RULE18: Programmer sums bit weights into each word.
// RULE19: Programmer writes page index before mapping words.
// RULE20: Actions apply only while row conditions hold.
// RULE21: Same bit from several rows is ORed.
package row_action_pkg;

  localparam logic [9:0] CV_PAGE_INDEX = 10'h020;
  localparam logic [9:0] CV_LOGIC_A    = 10'h104;
  localparam logic [9:0] CV_LOGIC_B    = 10'h105;
  localparam logic [9:0] CV_LOGIC_C    = 10'h106;
  localparam logic [9:0] CV_SOUND_A    = 10'h107;
  localparam logic [9:0] CV_SOUND_B    = 10'h108;
  localparam logic [9:0] CV_SOUND_C    = 10'h109;
  localparam logic [9:0] CV_SOUND_D    = 10'h10A;

  // Page that holds this row's action words.
  localparam logic [7:0] ROW_PAGE      = 8'h10;
  localparam logic [7:0] WORD_RESET    = 8'h00;
  localparam logic [7:0] PAGE_RESET    = 8'h00;

  localparam int         ROW_WORDS     = 7;
  localparam logic [2:0] W_LOGIC_A     = 3'h0;
  localparam logic [2:0] W_LOGIC_B     = 3'h1;
  localparam logic [2:0] W_LOGIC_C     = 3'h2;
  localparam logic [2:0] W_SOUND_A     = 3'h3;
  localparam logic [2:0] W_SOUND_B     = 3'h4;
  localparam logic [2:0] W_SOUND_C     = 3'h5;
  localparam logic [2:0] W_SOUND_D     = 3'h6;

  localparam int LA_OPT_LOAD     = 0;
  localparam int LA_SHUNT        = 1;
  localparam int LA_BRAKE_LO     = 2;
  localparam int LA_BRAKE_HI     = 4;
  localparam int LA_PRIMARY_LOAD = 5;
  localparam int LA_UNCOUPLE     = 6;
  localparam int LA_HOLD         = 7;
  localparam int LB_FIRE_BOX     = 0;
  localparam int LB_DIMMER       = 1;
  localparam int LB_CROSSING     = 2;
  localparam int LB_NO_DELAY     = 3;
  localparam int LB_SMOKE        = 4;
  localparam int LB_FADE         = 5;
  localparam int LB_MUTE_BRAKE   = 6;
  localparam int LB_VOLUME       = 7;
  localparam int LC_GEAR_LO      = 0;
  localparam int LC_GEAR_HI      = 5;

  localparam int SLOT_COUNT      = 32;
  localparam int MAX_PLAYING     = 10;

  localparam logic [2:0] VOL_FULL      = 3'h0;
  localparam logic [2:0] VOL_LAST_STEP = 3'h4;

  localparam int CLOCK_KHZ           = 250000;
  localparam int UNCOUPLE_PUSH_MS    = 500;
  localparam int UNCOUPLE_PULL_MS    = 500;
  localparam int UNCOUPLE_PUSH_CYCLES = UNCOUPLE_PUSH_MS * CLOCK_KHZ;
  localparam int UNCOUPLE_PULL_CYCLES = UNCOUPLE_PULL_MS * CLOCK_KHZ;

  typedef enum logic [2:0] {
    U_IDLE = 3'b001,
    U_PUSH = 3'b010,
    U_PULL = 3'b100
  } uncouple_state_t;

endpackage

//--- verilog/sound_slot_limiter.sv
module sound_slot_limiter
  import row_action_pkg::*;
(
  input  wire logic [SLOT_COUNT-1:0] request,
  output logic      [SLOT_COUNT-1:0] grant
);

  // Lower slots win, so the prime mover in slot one is never crowded out.
  always_comb begin
    int taken;
    taken = 0;
    grant = '0;
    for (int i = 0; i < SLOT_COUNT; i++) begin
      if (request[i] && (taken < MAX_PLAYING)) begin // [RULE17] [RULE16]
        grant[i] = 1'b1;
        taken    = taken + 1;
      end
    end
  end

endmodule

//--- verification/cv_programmer.sv
module cv_programmer
  import row_action_pkg::*;
(
  input  wire logic       clock,
  output logic            cv_wr,
  output logic            cv_rd,
  output logic [9:0]      cv_addr,
  output logic [7:0]      cv_wdata,
  input  wire logic [7:0] cv_rdata,
  input  wire logic       cv_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cv_wr    = 1'b0;
    cv_rd    = 1'b0;
    cv_addr  = 10'h3FF;
    cv_wdata = 8'hFF;
  end

  // Idle lines show the inverse of the last value, so a design that samples
  // outside the strobe sees garbage rather than a lucky leftover.
  task automatic put(input logic [9:0] addr, input logic [7:0] data);
    @(negedge clock);
    cv_wr    = 1'b1;
    cv_addr  = addr;
    cv_wdata = data;
    @(negedge clock);
    cv_wr    = 1'b0;
    cv_addr  = ~addr;
    cv_wdata = ~data;
  endtask

  // Row indices repeat on other pages, so the page goes out first.
  task automatic write_row(input logic [9:0] addr, input logic [7:0] data);
    put(CV_PAGE_INDEX, ROW_PAGE);
    put(addr, data);
  endtask

  task automatic get(input logic [9:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clock);
    cv_rd   = 1'b1;
    cv_addr = addr;
    @(negedge clock);
    ok      = cv_rvalid;
    data    = cv_rdata;
    cv_rd   = 1'b0;
    cv_addr = ~addr;
  endtask
endmodule

//--- verification/test_mapping_row_action_select.sv
module test_mapping_row_action_select
  import row_action_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  clock;
  logic                  rstn;
  logic                  cv_wr;
  logic                  cv_rd;
  logic [9:0]            cv_addr;
  logic [7:0]            cv_wdata;
  logic [7:0]            cv_rdata;
  logic                  cv_rvalid;
  logic                  row_match;
  logic [7:0]            other_logic_a;
  logic [7:0]            other_logic_b;
  logic [7:0]            other_logic_c;
  logic [SLOT_COUNT-1:0] other_sound;
  logic                  speed_hold;
  logic                  shunting_mode;
  logic                  optional_load;
  logic                  primary_load;
  logic [2:0]            brake_select;
  logic                  uncouple_push;
  logic                  uncouple_pull;
  logic                  fire_box;
  logic                  dimmer;
  logic                  grade_crossing;
  logic                  bypass_delay;
  logic                  smoke_on;
  logic                  sound_fade;
  logic                  brake_sound_mute;
  logic [2:0]            volume_step;
  logic [5:0]            gear_state;
  logic [SLOT_COUNT-1:0] slot_play;
  logic [6:0]            la_out;
  logic [6:0]            lb_out;
  int                    fails;
  int                    checked;
  int                    n;

  assign la_out = {speed_hold, primary_load, brake_select, shunting_mode, optional_load};
  assign lb_out = {brake_sound_mute, sound_fade, smoke_on, bypass_delay, grade_crossing,
                   dimmer, fire_box};

  mapping_row_action_select #(.PUSH_CYCLES(8), .PULL_CYCLES(8)) DUT (
    .clock(clock), .rstn(rstn), .cv_wr(cv_wr), .cv_rd(cv_rd), .cv_addr(cv_addr),
    .cv_wdata(cv_wdata), .cv_rdata(cv_rdata), .cv_rvalid(cv_rvalid),
    .row_match(row_match), .other_logic_a(other_logic_a), .other_logic_b(other_logic_b),
    .other_logic_c(other_logic_c), .other_sound(other_sound), .speed_hold(speed_hold),
    .shunting_mode(shunting_mode), .optional_load(optional_load),
    .primary_load(primary_load), .brake_select(brake_select),
    .uncouple_push(uncouple_push), .uncouple_pull(uncouple_pull), .fire_box(fire_box),
    .dimmer(dimmer), .grade_crossing(grade_crossing), .bypass_delay(bypass_delay),
    .smoke_on(smoke_on), .sound_fade(sound_fade), .brake_sound_mute(brake_sound_mute),
    .volume_step(volume_step), .gear_state(gear_state), .slot_play(slot_play)
  );

  cv_programmer prog (
    .clock(clock), .cv_wr(cv_wr), .cv_rd(cv_rd), .cv_addr(cv_addr),
    .cv_wdata(cv_wdata), .cv_rdata(cv_rdata), .cv_rvalid(cv_rvalid)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_check(input logic [9:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    prog.get(addr, d, ok);
    check(32'(ok), 32'h1);
    check(32'(d), 32'(exp));
  endtask

  task automatic settle();
    repeat (3) @(negedge clock);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #80000;
    fails++;
    final_report();
  end

  initial begin
    fails = 0;
    checked = 0;
    rstn = 1'b0;
    row_match = 1'b0;
    other_logic_a = 8'h00;
    other_logic_b = 8'h00;
    other_logic_c = 8'h00;
    other_sound = '0;
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    check({la_out, lb_out, gear_state, volume_step, uncouple_push, uncouple_pull}, 0);
    check(slot_play, 0);
    rd_check(CV_PAGE_INDEX, PAGE_RESET);
    for (int i = 0; i < ROW_WORDS; i++) rd_check(CV_LOGIC_A + 10'(i), WORD_RESET);
    // A row write on the wrong page must not land.
    prog.put(CV_LOGIC_A, 8'hBF);
    rd_check(CV_LOGIC_A, 8'h00);
    prog.put(CV_SOUND_A, 8'h5A);
    rd_check(CV_SOUND_A, 8'h00);
    prog.write_row(CV_LOGIC_B, 8'h00);
    rd_check(CV_PAGE_INDEX, ROW_PAGE);
    // Once the page is right, the earlier foreign-page writes must still be absent.
    rd_check(CV_LOGIC_A, WORD_RESET);
    rd_check(CV_SOUND_A, WORD_RESET);
    for (int i = 0; i < ROW_WORDS; i++) prog.put(CV_LOGIC_A + 10'(i), 8'h3C ^ 8'(i));
    for (int i = 0; i < ROW_WORDS; i++) rd_check(CV_LOGIC_A + 10'(i), 8'h3C ^ 8'(i));
    rd_check(10'h3FF, 8'h00);
    check({la_out, lb_out, gear_state}, 0);
    check(slot_play, 0);
    row_match = 1'b1;
    prog.put(CV_LOGIC_A, 8'hBF);
    prog.put(CV_LOGIC_B, 8'h7F);
    prog.put(CV_LOGIC_C, 8'hFF);
    prog.put(CV_SOUND_A, 8'h03);
    prog.put(CV_SOUND_B, 8'h00);
    prog.put(CV_SOUND_C, 8'h00);
    prog.put(CV_SOUND_D, 8'h80);
    settle();
    check(la_out, 7'h7F);
    check(lb_out, 7'h7F);
    check(gear_state, 6'h3F);
    check(slot_play, 32'h8000_0003);
    row_match = 1'b0;
    settle();
    check({la_out, lb_out, gear_state}, 0);
    check(slot_play, 0);
    other_logic_a = 8'h25;
    other_logic_b = 8'h55;
    other_logic_c = 8'hC3;
    other_sound = 32'h0000_1000;
    settle();
    check(la_out, {1'b0, 1'b1, 3'b001, 1'b0, 1'b1});
    check(lb_out, 7'h55);
    check(gear_state, 6'h03);
    check(slot_play, 32'h0000_1000);
    row_match = 1'b1;
    other_sound = 32'h0000_0F0F;
    for (int i = 0; i < 3; i++) prog.put(CV_SOUND_A + 10'(i), 8'h00);
    settle();
    check(slot_play, 32'h8000_0F0F);
    other_sound = 32'h0000_FF0F;
    settle();
    check(slot_play, 32'h0000_3F0F);
    other_sound = '0;
    for (int i = 0; i < 4; i++) prog.put(CV_SOUND_A + 10'(i), 8'hFF);
    settle();
    check(slot_play, 32'h0000_03FF);
    other_logic_a = 8'h00;
    other_logic_b = 8'h00;
    other_logic_c = 8'h00;
    prog.put(CV_LOGIC_A, 8'h40);
    n = 0;
    while (uncouple_push !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    check(32'(uncouple_push), 1);
    n = 0;
    while (uncouple_push === 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check(n, 8);
    check(32'(uncouple_pull), 1);
    n = 0;
    while (uncouple_pull === 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check(n, 8);
    check({uncouple_push, uncouple_pull}, 0);
    prog.put(CV_LOGIC_A, 8'h00);
    prog.put(CV_LOGIC_B, 8'h00);
    // Each press and release steps down; the press after the last step restores.
    for (int p = 1; p <= 5; p++) begin
      other_logic_b = 8'h80;
      repeat (2) @(negedge clock);
      other_logic_b = 8'h00;
      settle();
      check(volume_step, (p == 5) ? 0 : p);
    end
    final_report();
  end
endmodule
